// >>> sct_ctrl_model.sv
// Memory controller model driving command, mask and write data pins
`timescale 1ns/100ps
module sct_ctrl_model (
   // Clock
   input wire logic clk,
   // Pins toward the device
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [11:0] addr,
   output logic [1:0] dqm,
   output logic [15:0] dq_in
);
   // ======================================================================
   // Idle pins at time zero
   initial begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = sct_pkg::CMD_NOP;
      addr = 12'h000;
      dqm = 2'b00;
      dq_in = 16'h0000;
   end

   // One command, launched after an edge and held until the next call
   task automatic cmd(input logic e, input sct_pkg::sct_cmd_t c,
         input logic [11:0] a, input logic [1:0] m, input logic [15:0] d,
         input logic dv);
      @(posedge clk);
      cke <= e;
      {cs_n, ras_n, cas_n, we_n} <= c;
      addr <= a;
      dqm <= m;
      // Write data rides with its command; else the bus wanders
      dq_in <= dv ? d : ~dq_in;
   endtask : cmd

   // Idle cycles are filled with no-operation
   task automatic idle(input int n);
      repeat (n) cmd(1'b1, sct_pkg::CMD_NOP, 12'h000, 2'b00, 16'h0, 1'b0);
   endtask : idle
endmodule : sct_ctrl_model

// >>> sct_fifo.sv
// Fall-through FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sct_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // ======================================================================
   // Storage and pointers; depth must be a power of two
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];    // Word storage
   logic [PW-1:0] wp_q;                // Write pointer
   logic [PW-1:0] rp_q;                // Read pointer
   logic [PW:0] cnt_q;                 // Words held
   logic empty;
   logic bypass;
   logic push;
   logic pop;

   // When empty, a word falls straight through so no latency is added
   assign empty = (cnt_q == '0);
   assign in_ready = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = !empty || in_valid;
   assign out_data = empty ? in_data : mem_q[rp_q];
   assign bypass = empty && out_ready;
   assign push = in_valid && in_ready && !bypass;
   assign pop = !empty && out_ready;

   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : sct_fifo

// >>> sct_mem.sv
// Word array with byte-lane write and registered read
`timescale 1ns/100ps
module sct_mem #(
   parameter int AW = 20,
   parameter int DW = 16
) (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [DW/8-1:0] wbe,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   // ======================================================================
   // Array, not reset: contents are undefined at power-up as in the part
   logic [DW-1:0] arr_q [2**AW];

   // Byte-lane write
   always_ff @(posedge clk) begin
      for (int l = 0; l < DW/8; l++) begin
         if (we && wbe[l]) begin
            arr_q[waddr][l*8 +: 8] <= wdata[l*8 +: 8];
         end
      end
   end

   // Registered read
   always_ff @(posedge clk) begin
      if (re) begin
         rdata <= arr_q[raddr];
      end
   end
endmodule : sct_mem

// >>> sct_pkg.sv
// Shared constants, types and helpers of the synchronous DRAM command block
// ==========================================================================
// Contract
// - Read data appears after CAS latency
// - Column commands accepted every cycle
// - Burst stop floats reads, drops writes
// - Precharge floats reads, drops writes
// - Byte mask: reads two late, writes immediate
// - Mode load captures A0-A11, banks idle
// - Activate opens row in selected bank
// - Precharge closes one or both banks
// - Read bursts from column in open bank
// - A10 high closes bank after burst
// - Auto-refresh uses internal address, blocks commands
// - Self-refresh while clock enable low, recovery
// - No-operation and deselect change nothing
package sct_pkg;

   // ======================================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 10;   // 100 MHz core clock
   localparam int T_RC_NS = 100;        // Refresh to refresh period
   localparam int T_RAC_NS = 60;        // Self-refresh exit recovery
   // Least times round up to whole cycles
   localparam int TRC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRAC_CYC = (T_RAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W = 4;            // Width of the busy timer

   // ======================================================================
   // Address pin roles
   localparam int AP_BIT = 10;          // Autoclose / both-bank select
   localparam int BANK_BIT = 11;        // Bank select

   // ======================================================================
   // Mode word layout and reset value
   localparam int MR_BL_LSB = 0;        // Burst length code, 3 bits
   localparam int MR_CL_LSB = 4;        // CAS latency code, 3 bits
   localparam int MR_WS_BIT = 9;        // Single-word write bursts
   localparam logic [2:0] MR_CL2 = 3'h2;      // Code for latency two
   localparam logic [11:0] MR_RESET = 12'h030; // Latency three, length one

   // ======================================================================
   // Command codes from {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      CMD_MODE   = 4'b0000,
      CMD_REFR   = 4'b0001,
      CMD_PRECH  = 4'b0010,
      CMD_ACTV   = 4'b0011,
      CMD_WRITE  = 4'b0100,
      CMD_READ   = 4'b0101,
      CMD_BSTOP  = 4'b0110,
      CMD_NOP    = 4'b0111,
      CMD_DESEL  = 4'b1111
   } sct_cmd_t;

   // Array-level states
   typedef enum logic [1:0] {
      ST_RUN     = 2'b00,
      ST_REFRESH = 2'b01,
      ST_SELF    = 2'b10,
      ST_RECOVER = 2'b11
   } sct_state_t;

   // Burst length from the mode code; reserved codes act as one
   function automatic logic [8:0] burst_len(input logic [2:0] code);
      case (code)
         3'h0: burst_len = 9'h001;
         3'h1: burst_len = 9'h002;
         3'h2: burst_len = 9'h004;
         3'h3: burst_len = 9'h008;
         3'h7: burst_len = 9'h100;
         default: burst_len = 9'h001;
      endcase
   endfunction : burst_len

endpackage : sct_pkg

// >>> sct_sdram.sv
// Two-bank synchronous DRAM: command decode, bursts, refresh, data pins
`timescale 1ns/100ps
module sct_sdram #(
   parameter int ROW_W = 11,
   parameter int COL_W = 8,
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Command pins
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [11:0] addr,
   input wire logic [1:0] dqm,
   // Data pins, split into in, out and per-lane enable
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic [1:0] dq_oe_n,
   // Status
   output logic [1:0] bank_open,
   output logic [11:0] mode_word,
   output logic self_refresh,
   output logic [ROW_W-1:0] refresh_row
);
   // ======================================================================
   // Declarations
   localparam int AW = 1 + ROW_W + COL_W;
   localparam int TMR_W_L = sct_pkg::TMR_W;
   logic rst_s1_q;                 // Reset release, first stage
   logic rst_n;                    // Reset release, used copy
   logic cke_prev_q;               // Clock enable of the previous edge
   sct_pkg::sct_state_t state_q;   // Array state
   logic [TMR_W_L-1:0] tmr_q;      // Busy timer
   logic [ROW_W-1:0] row_q [2];    // Open row per bank
   sct_pkg::sct_cmd_t cmd;         // Decoded command
   logic run;                      // Internal clock advances this cycle
   logic live;                     // Commands are taken this cycle
   logic stop;                     // Current burst is cut this cycle
   logic col_cmd;                  // Read or write command
   // Burst registers
   logic bst_act_q;
   logic bst_wr_q;
   logic bst_ap_q;
   logic bst_bank_q;
   logic [COL_W-1:0] bst_col_q;
   logic [COL_W-1:0] bst_msk_q;    // Wrap mask of the burst
   logic [8:0] bst_left_q;         // Accesses still to do
   // Access of this cycle
   logic a_go;
   logic a_adv;
   logic a_wr;
   logic a_ap;
   logic a_bank;
   logic [COL_W-1:0] a_col;
   logic [COL_W-1:0] a_msk;
   logic [8:0] a_left;
   logic [COL_W-1:0] a_nxt;
   logic [AW-1:0] a_addr;
   logic close_now;                // Autoclose at burst end
   // Read path
   logic cl2;                      // Latency two selected
   logic rd_vld_q;                 // Array data valid this cycle
   logic [1:0] due_q;              // Output due line
   logic pop;
   logic [15:0] mem_rdata;
   logic fill_rdy;
   logic fo_valid;
   logic [15:0] fo_data;
   logic [1:0] dqm_q1;             // Mask sampled one edge ago

   // ======================================================================
   // Reset release through two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // ======================================================================
   // Command decode
   // Clock enable low at the last edge suspends the internal clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cke_prev_q <= 1'b0;
      end else begin
         cke_prev_q <= cke;
      end
   end

   assign cmd = sct_pkg::sct_cmd_t'({cs_n, ras_n, cas_n, we_n});
   assign run = cke_prev_q && (state_q == sct_pkg::ST_RUN);
   // Commands are blocked while a refresh or recovery is running
   assign live = run;
   assign col_cmd = live && (cmd == sct_pkg::CMD_READ ||
                             cmd == sct_pkg::CMD_WRITE);
   // Burst stop, or precharge hitting the burst bank, cuts the burst
   always_comb begin
      stop = 1'b0;
      if (live && bst_act_q) begin
         if (cmd == sct_pkg::CMD_BSTOP) begin
            stop = 1'b1;
         end else if (cmd == sct_pkg::CMD_PRECH) begin
            stop = addr[sct_pkg::AP_BIT] ||
                   (addr[sct_pkg::BANK_BIT] == bst_bank_q);
         end
      end
   end

   // ======================================================================
   // Array state: auto-refresh, self-refresh and its recovery
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= sct_pkg::ST_RUN;
         tmr_q <= '0;
         self_refresh <= 1'b0;
      end else begin
         case (state_q)
            sct_pkg::ST_RUN: begin
               if (live && cmd == sct_pkg::CMD_REFR) begin
                  if (!cke) begin
                     // Refresh with clock enable falling enters self mode
                     state_q <= sct_pkg::ST_SELF;
                     self_refresh <= 1'b1;
                  end else begin
                     state_q <= sct_pkg::ST_REFRESH;
                     tmr_q <= TMR_W_L'(sct_pkg::TRC_CYC - 2);
                  end
               end
            end
            sct_pkg::ST_REFRESH: begin
               // Busy for the row-cycle period, then idle again
               if (tmr_q == '0) begin
                  state_q <= sct_pkg::ST_RUN;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            sct_pkg::ST_SELF: begin
               // Clock enable high ends self mode and starts recovery
               if (cke) begin
                  state_q <= sct_pkg::ST_RECOVER;
                  self_refresh <= 1'b0;
                  tmr_q <= TMR_W_L'(sct_pkg::TRAC_CYC - 2);
               end
            end
            sct_pkg::ST_RECOVER: begin
               if (tmr_q == '0) begin
                  state_q <= sct_pkg::ST_RUN;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            default: begin
               state_q <= sct_pkg::ST_RUN;
            end
         endcase
      end
   end

   // Internal refresh row: bumped per auto-refresh and per self cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refresh_row <= '0;
      end else if ((live && cmd == sct_pkg::CMD_REFR && cke) ||
                   state_q == sct_pkg::ST_SELF) begin
         refresh_row <= refresh_row + 1'b1;
      end
   end

   // ======================================================================
   // Mode register load from all twelve address pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_word <= sct_pkg::MR_RESET;
      end else if (live && cmd == sct_pkg::CMD_MODE) begin
         mode_word <= addr;
      end
   end

   assign cl2 = (mode_word[sct_pkg::MR_CL_LSB +: 3] == sct_pkg::MR_CL2);

   // ======================================================================
   // Bank open flags; a command in the same cycle overrides autoclose
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_open <= 2'b00;
      end else begin
         if (close_now) begin
            bank_open[a_bank] <= 1'b0;
         end
         if (live) begin
            case (cmd)
               sct_pkg::CMD_ACTV: begin
                  bank_open[addr[sct_pkg::BANK_BIT]] <= 1'b1;
               end
               sct_pkg::CMD_PRECH: begin
                  if (addr[sct_pkg::AP_BIT]) begin
                     bank_open <= 2'b00;
                  end else begin
                     bank_open[addr[sct_pkg::BANK_BIT]] <= 1'b0;
                  end
               end
               // No-operation, deselect and the rest keep the flags
               default: begin
               end
            endcase
         end
      end
   end

   // Open row per bank
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         row_q[0] <= '0;
         row_q[1] <= '0;
      end else if (live && cmd == sct_pkg::CMD_ACTV) begin
         row_q[addr[sct_pkg::BANK_BIT]] <= addr[ROW_W-1:0];
      end
   end

   // ======================================================================
   // Access of this cycle: a new column command, or the running burst
   always_comb begin
      a_go = 1'b0;
      a_wr = bst_wr_q;
      a_ap = bst_ap_q;
      a_bank = bst_bank_q;
      a_col = bst_col_q;
      a_msk = bst_msk_q;
      a_left = bst_left_q;
      if (col_cmd) begin
         // A new column command replaces any burst at once
         a_go = 1'b1;
         a_wr = (cmd == sct_pkg::CMD_WRITE);
         a_ap = addr[sct_pkg::AP_BIT];
         a_bank = addr[sct_pkg::BANK_BIT];
         a_col = addr[COL_W-1:0];
         a_left = sct_pkg::burst_len(mode_word[sct_pkg::MR_BL_LSB +: 3]);
         if (a_wr && mode_word[sct_pkg::MR_WS_BIT]) begin
            a_left = 9'h001;
         end
         a_msk = COL_W'(a_left - 9'h001);
      end else if (bst_act_q && run && !stop) begin
         a_go = 1'b1;
      end
   end

   // Reads stall when the output buffer cannot take more words
   assign a_adv = a_go && (a_wr || fill_rdy);
   assign a_nxt = (a_col & ~a_msk) | (COL_W'(a_col + 1'b1) & a_msk);
   assign close_now = a_adv && a_ap && (a_left == 9'h001);
   assign a_addr = {a_bank, row_q[a_bank], a_col};

   // Burst registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bst_act_q <= 1'b0;
         bst_wr_q <= 1'b0;
         bst_ap_q <= 1'b0;
         bst_bank_q <= 1'b0;
         bst_col_q <= '0;
         bst_msk_q <= '0;
         bst_left_q <= '0;
      end else if (stop) begin
         bst_act_q <= 1'b0;
      end else if (a_go) begin
         bst_wr_q <= a_wr;
         bst_ap_q <= a_ap;
         bst_bank_q <= a_bank;
         bst_msk_q <= a_msk;
         if (a_adv) begin
            bst_act_q <= (a_left != 9'h001);
            bst_left_q <= a_left - 9'h001;
            bst_col_q <= a_nxt;
         end else begin
            bst_act_q <= 1'b1;
            bst_left_q <= a_left;
            bst_col_q <= a_col;
         end
      end
   end

   // ======================================================================
   // Array; write data and mask are taken in the command cycle itself
   sct_mem #(
      .AW(AW),
      .DW(16)
   ) u_mem (
      .clk(clk),
      .we(a_adv && a_wr),
      .wbe(~dqm),
      .waddr(a_addr),
      .wdata(dq_in),
      .re(a_adv && !a_wr),
      .raddr(a_addr),
      .rdata(mem_rdata)
   );

   // ======================================================================
   // Read pipeline: array word valid one cycle after the access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_vld_q <= 1'b0;
      end else begin
         rd_vld_q <= a_adv && !a_wr;
      end
   end

   // Due line freezes with the internal clock so suspend keeps alignment
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         due_q <= 2'b00;
      end else if (cke_prev_q) begin
         due_q <= {due_q[0], a_adv && !a_wr};
      end
   end

   // Pop one cycle before the output edge of the selected latency
   assign pop = cke_prev_q && (cl2 ? due_q[0] : due_q[1]);

   sct_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(rd_vld_q),
      .in_ready(fill_rdy),
      .in_data(mem_rdata),
      .out_valid(fo_valid),
      .out_ready(pop),
      .out_data(fo_data)
   );

   // Mask is delayed one edge here and one in the output flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dqm_q1 <= 2'b11;
      end else begin
         dqm_q1 <= dqm;
      end
   end

   // Output flops: lanes float when no word is due; they hold while clock enable was low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_out <= 16'h0000;
         dq_oe_n <= 2'b11;
      end else if (cke_prev_q) begin
         if (pop && fo_valid) begin
            dq_out <= fo_data;
         end
         for (int l = 0; l < 2; l++) begin
            dq_oe_n[l] <= !(pop && fo_valid && !dqm_q1[l]);
         end
      end
   end
endmodule : sct_sdram

// >>> sct_sdram_checker.sv
// Port-level timing checks for the two-bank synchronous DRAM block
`timescale 1ns/100ps
module sct_sdram_checker #(
   parameter int ROW_W = 11
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Command pins
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [11:0] addr,
   input wire logic [1:0] dqm,
   // Data pins
   input wire logic [15:0] dq_in,
   input wire logic [15:0] dq_out,
   input wire logic [1:0] dq_oe_n,
   // Status
   input wire logic [1:0] bank_open,
   input wire logic [11:0] mode_word,
   input wire logic self_refresh,
   input wire logic [ROW_W-1:0] refresh_row
);
   // ======================================================================
   // Helper state
   logic cke_q; // Clock enable at the previous edge
   logic [3:0] busy_q; // Refresh cycles still blocking commands
   logic [3:0] cmd; // Strobes as one command code
   logic ok; // A command at this edge is taken
   logic cl3; // Latency three selected
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign ok = cke_q && busy_q == 4'h0 && !self_refresh;
   assign cl3 = mode_word[6:4] != sct_pkg::MR_CL2;

   // Previous clock enable, low out of reset like the design's copy
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cke_q <= 1'b0;
      end else begin
         cke_q <= cke;
      end
   end

   // Refresh busy window; recovery after self-refresh is left to the bench
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_q <= 4'h0;
      end else if (ok && cke && cmd == sct_pkg::CMD_REFR) begin
         busy_q <= 4'(sct_pkg::TRC_CYC - 1);
      end else if (busy_q != 4'h0) begin
         busy_q <= busy_q - 4'h1;
      end
   end

   // ======================================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_rd3; ok && cl3 && cmd == sct_pkg::CMD_READ; endsequence
   sequence s_rd2; ok && !cl3 && cmd == sct_pkg::CMD_READ; endsequence
   sequence s_clean; dqm == 2'b00 && cke; endsequence

   AST_RD_CL3: assert property (
      s_rd3 ##1 s_clean |-> ##2 dq_oe_n == 2'b00)
      else $error("read word late at latency three");
   AST_RD_CL2: assert property (
      s_rd2 ##0 s_clean |-> ##2 dq_oe_n == 2'b00)
      else $error("read word late at latency two");
   AST_MASK_RD: assert property (
      (dqm[0] && cke) ##1 cke |-> ##1 dq_oe_n[0])
      else $error("masked low lane still driven");
   AST_BSTOP_FLOAT: assert property (
      ok && cke && cmd == sct_pkg::CMD_BSTOP |->
      if (cl3) ##3 dq_oe_n == 2'b11 else ##2 dq_oe_n == 2'b11)
      else $error("outputs driven after burst stop");
   AST_PRE_FLOAT: assert property (
      ok && cmd == sct_pkg::CMD_PRECH && addr[10] |->
      if (cl3) ##3 dq_oe_n == 2'b11 else ##2 dq_oe_n == 2'b11)
      else $error("outputs driven after precharge");
   AST_PRE_ALL: assert property (
      ok && cmd == sct_pkg::CMD_PRECH && addr[10] |=> bank_open == 2'b00)
      else $error("bank left open by full precharge");
   AST_ACT_OPEN: assert property (
      ok && cmd == sct_pkg::CMD_ACTV |=> bank_open[$past(addr[11])])
      else $error("activated bank not open");
   AST_MODE_LOAD: assert property (
      ok && cmd == sct_pkg::CMD_MODE |=> mode_word == $past(addr))
      else $error("mode word not captured");
   AST_IDLE_CMD: assert property (
      ok && (cs_n || cmd == sct_pkg::CMD_NOP) |=>
      $stable(mode_word) && $stable(self_refresh))
      else $error("idle command changed state");
   AST_REF_ROW: assert property (
      ok && cke && cmd == sct_pkg::CMD_REFR |=>
      refresh_row == $past(refresh_row) + ROW_W'(1))
      else $error("refresh row not advanced");
   AST_SELF_ENTER: assert property (
      ok && !cke && cmd == sct_pkg::CMD_REFR |=> self_refresh [*2])
      else $error("self-refresh not entered");
endmodule : sct_sdram_checker

// >>> tb_sdram_command_timing.sv
// Self-checking testbench for the two-bank synchronous DRAM block
`timescale 1ns/100ps
module tb_sdram_command_timing;
   // ======================================================================
   // Pins and counters
   logic clk;
   logic nrst;
   logic cke, cs_n, ras_n, cas_n, we_n;
   logic [11:0] addr, mode_word;
   logic [1:0] dqm, dq_oe_n, bank_open;
   logic [15:0] dq_in, dq_out;
   logic self_refresh;
   logic [10:0] refresh_row;
   int fail_count;
   int n_compared;

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   sct_sdram sct_sdram_i (.*);
   sct_ctrl_model sct_ctrl_model_i (.*);

   // ======================================================================
   // Shared tasks
   task automatic op(input sct_pkg::sct_cmd_t c, input logic [11:0] a,
         input logic [1:0] m = 2'b00, input logic [15:0] d = 16'h0,
         input logic dv = 1'b0);
      sct_ctrl_model_i.cmd(1'b1, c, a, m, d, dv);
   endtask : op

   task automatic idle(input int n);
      sct_ctrl_model_i.idle(n);
   endtask : idle

   task automatic check(input string name, input logic [15:0] seen,
         input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic end_sim;
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   // ======================================================================
   // Scenarios
   // Mode load, then activates to both banks two cycles apart
   task automatic t_mode_act;
      op(sct_pkg::CMD_MODE, 12'h031);
      idle(2);
      #1;
      check("mode_word", 16'(mode_word), 16'h0031);
      op(sct_pkg::CMD_ACTV, 12'h855);
      idle(1);
      #1;
      check("bank_open", 16'(bank_open), 16'h0002);
      op(sct_pkg::CMD_ACTV, 12'h055);
      idle(2);
      #1;
      check("bank_open", 16'(bank_open), 16'h0003);
      $display("test mode_act done");
   endtask : t_mode_act

   // Back-to-back writes with a byte mask, then a masked read-back
   task automatic t_wr_rd;
      op(sct_pkg::CMD_WRITE, 12'h804, 2'b00, 16'h1234, 1'b1);
      op(sct_pkg::CMD_WRITE, 12'h804, 2'b10, 16'h5678, 1'b1);
      op(sct_pkg::CMD_NOP, 12'h000, 2'b00, 16'h9abc, 1'b1);
      idle(2);
      op(sct_pkg::CMD_READ, 12'h804);
      op(sct_pkg::CMD_NOP, 12'h000);
      op(sct_pkg::CMD_NOP, 12'h000, 2'b01);
      op(sct_pkg::CMD_NOP, 12'h000);
      #1;
      check("dq_oe_n", 16'(dq_oe_n), 16'h0000);
      check("dq_out", dq_out, 16'h1278);
      @(posedge clk);
      #1;
      check("dq_oe_n", 16'(dq_oe_n), 16'h0001);
      check("dq_out hi", 16'(dq_out[15:8]), 16'h009a);
      @(posedge clk);
      #1;
      check("dq_oe_n", 16'(dq_oe_n), 16'h0003);
      $display("test wr_rd done");
   endtask : t_wr_rd

   // Full precharge, latency two, burst stop, then an autoclosing read
   task automatic t_stop;
      int i;
      op(sct_pkg::CMD_PRECH, 12'h400);
      idle(3);
      #1;
      check("bank_open", 16'(bank_open), 16'h0000);
      op(sct_pkg::CMD_MODE, 12'h022);
      idle(2);
      op(sct_pkg::CMD_ACTV, 12'h012);
      idle(2);
      op(sct_pkg::CMD_READ, 12'h000);
      op(sct_pkg::CMD_BSTOP, 12'h000);
      op(sct_pkg::CMD_NOP, 12'h000);
      #1;
      check("dq_oe_n", 16'(dq_oe_n), 16'h0000);
      @(posedge clk);
      #1;
      check("dq_oe_n", 16'(dq_oe_n), 16'h0003);
      op(sct_pkg::CMD_READ, 12'h400);
      op(sct_pkg::CMD_NOP, 12'h000);
      for (i = 0; i < 12 && bank_open !== 2'b00; i++) begin
         @(posedge clk);
         #1;
      end
      check("bank_open", 16'(bank_open), 16'h0000);
      if (i == 12) begin
         end_sim();
      end
      $display("test stop done");
   endtask : t_stop

   // Auto-refresh refuses commands; self-refresh follows clock enable
   task automatic t_refresh;
      idle(3);
      op(sct_pkg::CMD_REFR, 12'h000);
      idle(2);
      #1;
      check("refresh_row", 16'(refresh_row), 16'h0001);
      op(sct_pkg::CMD_ACTV, 12'h055);
      idle(1);
      #1;
      check("bank_open", 16'(bank_open), 16'h0000);
      idle(8);
      sct_ctrl_model_i.cmd(1'b0, sct_pkg::CMD_REFR, 12'h0, 2'b0, 16'h0, 1'b0);
      sct_ctrl_model_i.cmd(1'b0, sct_pkg::CMD_DESEL, 12'h0, 2'b0, 16'h0, 1'b0);
      #1;
      check("self_refresh", 16'(self_refresh), 16'h0001);
      op(sct_pkg::CMD_DESEL, 12'h000);
      idle(2);
      #1;
      check("self_refresh", 16'(self_refresh), 16'h0000);
      idle(7);
      $display("test refresh done");
   endtask : t_refresh

   // ======================================================================
   // Main sequence
   initial begin
      fail_count = 0;
      n_compared = 0;
      nrst = 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      idle(5);
      #1;
      check("mode_word", 16'(mode_word), 16'h0030);
      check("dq_oe_n", 16'(dq_oe_n), 16'h0003);
      check("bank_open", 16'(bank_open), 16'h0000);
      $display("test reset done");
      t_mode_act();
      t_wr_rd();
      t_stop();
      t_refresh();
      end_sim();
   end
endmodule : tb_sdram_command_timing

bind sct_sdram sct_sdram_checker #(.ROW_W(ROW_W)) sct_sdram_checker_i (.*);
